// ==== hdl/smc_consts.svh ====
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// register byte addresses
`define SMC_ADDR_OSC_SETTLE_TIME_SELECT 32'hFFFF_F6C0
`define SMC_ADDR_PSC  32'hFFFF_F6C4
`define SMC_ADDR_POWER_SAVE_MODE_REG 32'hFFFF_F6C8
`define SMC_ADDR_STAT 32'hFFFF_F6CC

// power save control field positions
`define SMC_PSC_WDT2  7
`define SMC_PSC_NMI   5
`define SMC_PSC_MASKABLE_WAKE_BLOCK  4
`define SMC_PSC_STP   1

// power save mode field position
`define SMC_POWER_SAVE_MODE_REG_SEL  0

// reset values
`define SMC_POWER_SAVE_MODE_REG_RST  8'h00
`define SMC_OSC_SETTLE_TIME_SELECT_RST  3'h1

// settle counter width and exponents per select code, code 7 first
`define SMC_CNT_W     22
`define SMC_SETTLE_EXP {5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0F, 5'h0D}

`endif

// ==== hdl/smc_pkg.sv ====
package smc_pkg;

  typedef enum logic [5:0] {
    SMC_NORMAL   = 6'h01,
    SMC_HALT     = 6'h02,
    SMC_IDLE     = 6'h04,
    SMC_STOP     = 6'h08,
    SMC_OSC_WAIT = 6'h10,
    SMC_SETTLE   = 6'h20
  } smc_state_t;

  typedef struct packed {
    logic nmi_pin;
    logic second_watchdog_irq;
    logic maskable;
  } smc_wake_t;

  typedef struct packed {
    logic osc_en;
    logic cpu_en;
    logic periph_en;
  } smc_clk_t;

  typedef struct packed {
    smc_state_t  state;
    logic        watchdog2_wake_block;
    logic        nmi_pin_wake_block;
    logic        maskable_wake_block;
    logic        standby_type_select;
    logic [2:0]  osc_settle_time_select;
    logic [21:0] cnt;
    logic [31:0] rdata;
  } smc_regs_t;

endpackage

// ==== hdl/smc_top.sv ====
`timescale 1ns/10ps
`include "smc_consts.svh"
module smc_top
#(
  parameter logic [7:0][4:0] P_SETTLE_EXP = `SMC_SETTLE_EXP
)
(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [31:0]         i_paddr,
  input  wire logic [31:0]         i_pwdata,
  input  wire logic [3:0]          i_pstrb,
  output logic                     o_pready,
  output logic [31:0]              o_prdata,
  output logic                     o_pslverr,
  input  wire logic                i_halt_instr,
  input  wire smc_pkg::smc_wake_t  i_wake,
  input  wire logic                i_osc_running,
  output smc_pkg::smc_clk_t        o_clk,
  output logic                     o_standby,
  output logic                     o_settling
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_mapped(input logic [31:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      `SMC_ADDR_OSC_SETTLE_TIME_SELECT: hit = 1'b1;
      `SMC_ADDR_PSC:  hit = 1'b1;
      `SMC_ADDR_POWER_SAVE_MODE_REG: hit = 1'b1;
      `SMC_ADDR_STAT: hit = 1'b1;
      default:        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // stop request reads 0: the cpu can only read it while running
  function automatic logic [31:0] read_word(input logic [31:0]        addr,
                                            input smc_pkg::smc_regs_t r);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      `SMC_ADDR_OSC_SETTLE_TIME_SELECT:
      begin
        w[2:0] = r.osc_settle_time_select;
      end
      `SMC_ADDR_PSC:
      begin
        w[`SMC_PSC_WDT2] = r.watchdog2_wake_block;
        w[`SMC_PSC_NMI]  = r.nmi_pin_wake_block;
        w[`SMC_PSC_MASKABLE_WAKE_BLOCK] = r.maskable_wake_block;
        w[`SMC_PSC_STP]  = 1'b0;
      end
      `SMC_ADDR_POWER_SAVE_MODE_REG:
      begin
        w[`SMC_POWER_SAVE_MODE_REG_SEL] = r.standby_type_select;
      end
      `SMC_ADDR_STAT:
      begin
        w[5:0] = r.state;
      end
      default:
      begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  function automatic logic [21:0] settle_last(input logic [4:0] exp);
    logic [21:0] one;
    one = 22'h00_0001;
    return (one << exp) - one;
  endfunction

  // shared state test for the enables, the status outputs and the stop gate
  // one-hot codes, so each test is a single compare
  function automatic logic in_state(input smc_pkg::smc_state_t s,
                                    input smc_pkg::smc_state_t want);
    return (s == want);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  smc_pkg::smc_regs_t r_r;
  smc_pkg::smc_regs_t r_nxt;

  logic       setup;
  logic       wr;
  logic       stop_req;
  logic       wake_ok;
  logic       any_irq;
  logic [7:0] wbyte;
  logic       in_normal;
  logic       in_halt;
  logic       in_idle;
  logic       in_stop;
  logic       in_osc_wait;
  logic       in_settle;
  logic [2:0] wake_src;
  logic [2:0] wake_blk;
  logic [2:0] wake_pass;

  // reset value kept as a named constant so its bit can be picked
  localparam logic [7:0] POWER_SAVE_MODE_REG_RST = `SMC_POWER_SAVE_MODE_REG_RST;

  ////////////////////////////////////////////////////////////////////////////
  // settle terminal counts, one per select code

  // built once, so the settle compare is a mux and not a shifter
  // counter width caps the longest wait at 2^22 cycles; any exponent of 22 or more gives that wait
  logic [7:0][21:0] settle_end;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_settle_end
      assign settle_end[g] = settle_last(P_SETTLE_EXP[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state decode

  assign in_normal   = in_state(r_r.state, smc_pkg::SMC_NORMAL);
  assign in_halt     = in_state(r_r.state, smc_pkg::SMC_HALT);
  assign in_idle     = in_state(r_r.state, smc_pkg::SMC_IDLE);
  assign in_stop     = in_state(r_r.state, smc_pkg::SMC_STOP);
  assign in_osc_wait = in_state(r_r.state, smc_pkg::SMC_OSC_WAIT);
  assign in_settle   = in_state(r_r.state, smc_pkg::SMC_SETTLE);

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, read data captured in the setup cycle

  assign setup     = i_psel & ~i_penable;
  assign wr        = i_psel & i_penable & i_pwrite & i_pstrb[0];
  assign wbyte     = i_pwdata[7:0];
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);
  assign o_prdata  = r_r.rdata;

  // a stop request only counts from normal operation
  // outside normal the cpu is not running, so such a write is dropped
  assign stop_req = wr && (i_paddr == `SMC_ADDR_PSC) && wbyte[`SMC_PSC_STP]
                    && in_normal;

  // wake from idle or stop honours the block bits
  // gate order follows the wake struct: pin, second watchdog, maskable
  assign wake_src = i_wake;
  assign wake_blk = {r_r.nmi_pin_wake_block,
                     r_r.watchdog2_wake_block,
                     r_r.maskable_wake_block};

  genvar w;
  generate
    for (w = 0; w < 3; w++)
    begin : g_wake_gate
      assign wake_pass[w] = wake_src[w] & ~wake_blk[w];
    end
  endgenerate

  assign wake_ok = |wake_pass;

  // halt is left by any request, block bits do not apply there
  assign any_irq = |wake_src;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    r_nxt = r_r;

    if (setup && !i_pwrite)
    begin
      r_nxt.rdata = read_word(i_paddr, r_r);
    end

    if (wr)
    begin
      case (i_paddr)
        `SMC_ADDR_OSC_SETTLE_TIME_SELECT:
        begin
          // upper bits are not stored, so a stray 1 there is harmless
          r_nxt.osc_settle_time_select = wbyte[2:0];
        end
        `SMC_ADDR_PSC:
        begin
          if (!wbyte[`SMC_PSC_STP])
          begin
            r_nxt.watchdog2_wake_block = wbyte[`SMC_PSC_WDT2];
            r_nxt.nmi_pin_wake_block   = wbyte[`SMC_PSC_NMI];
            r_nxt.maskable_wake_block  = wbyte[`SMC_PSC_MASKABLE_WAKE_BLOCK];
          end
        end
        `SMC_ADDR_POWER_SAVE_MODE_REG:
        begin
          // bit access on the cpu side is a byte read-modify-write here
          r_nxt.standby_type_select = wbyte[`SMC_POWER_SAVE_MODE_REG_SEL];
        end
        default:
        begin
          r_nxt.rdata = r_r.rdata;
        end
      endcase
    end

    case (r_r.state)
      smc_pkg::SMC_NORMAL:
      begin
        if (stop_req)
        begin
          // select bit is only looked at together with a stop request
          r_nxt.state = r_r.standby_type_select ? smc_pkg::SMC_STOP
                                                : smc_pkg::SMC_IDLE;
        end
        else if (i_halt_instr)
        begin
          r_nxt.state = smc_pkg::SMC_HALT;
        end
      end
      smc_pkg::SMC_HALT:
      begin
        // a request already pending releases halt on the next edge
        if (any_irq)
        begin
          r_nxt.state = smc_pkg::SMC_NORMAL;
        end
      end
      smc_pkg::SMC_IDLE:
      begin
        // oscillator kept running, so no settle time is needed
        if (wake_ok)
        begin
          r_nxt.state = smc_pkg::SMC_NORMAL;
        end
      end
      smc_pkg::SMC_STOP:
      begin
        if (wake_ok)
        begin
          r_nxt.state = smc_pkg::SMC_OSC_WAIT;
          r_nxt.cnt   = 22'h00_0000;
        end
      end
      smc_pkg::SMC_OSC_WAIT:
      begin
        // time before oscillation is not counted
        if (i_osc_running)
        begin
          r_nxt.state = smc_pkg::SMC_SETTLE;
          r_nxt.cnt   = 22'h00_0000;
        end
      end
      smc_pkg::SMC_SETTLE:
      begin
        // no bypass for an external clock source
        if (r_r.cnt == settle_end[r_r.osc_settle_time_select])
        begin
          r_nxt.state = smc_pkg::SMC_NORMAL;
          r_nxt.cnt   = 22'h00_0000;
        end
        else
        begin
          r_nxt.cnt = r_r.cnt + 22'h00_0001;
        end
      end
      default:
      begin
        r_nxt.state = smc_pkg::SMC_OSC_WAIT;
        r_nxt.cnt   = 22'h00_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // reset starts in oscillator wait so the reset settle time is applied
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_r.state                  <= smc_pkg::SMC_OSC_WAIT;
      r_r.watchdog2_wake_block   <= 1'b0;
      r_r.nmi_pin_wake_block     <= 1'b0;
      r_r.maskable_wake_block    <= 1'b0;
      r_r.standby_type_select    <= POWER_SAVE_MODE_REG_RST[`SMC_POWER_SAVE_MODE_REG_SEL];
      r_r.osc_settle_time_select <= `SMC_OSC_SETTLE_TIME_SELECT_RST;
      r_r.cnt                    <= 22'h00_0000;
      r_r.rdata                  <= 32'h0000_0000;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gating outputs

  // halt gates only the cpu; peripherals and oscillator keep running
  // stop turns the oscillator off; idle keeps it, trading power for a fast wake
  assign o_clk.osc_en    = ~in_stop;
  assign o_clk.cpu_en    = in_normal;
  assign o_clk.periph_en = in_normal
                         | in_halt;
  assign o_standby       = in_idle
                         | in_stop;
  assign o_settling      = in_osc_wait
                         | in_settle;

endmodule

// ==== verification/smc_osc_model.sv ====
`timescale 1ns/10ps
module smc_osc_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc_en,
  input  wire logic [2:0] i_delay,
  output logic            o_osc_running
);
  logic [3:0] cnt_r;
  // start-up lag of the oscillator; zero lag stands for an external clock
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_r <= 4'h0;
    else if (!i_osc_en)
      cnt_r <= 4'h0;
    else if (cnt_r <= {1'b0, i_delay})
      cnt_r <= cnt_r + 4'h1;
  end
  // a stopped oscillator gives no clock at once, not a stale level
  assign o_osc_running = i_osc_en && cnt_r > {1'b0, i_delay};
endmodule

// ==== verification/smc_chk.sv ====
`timescale 1ns/10ps
`include "smc_consts.svh"
module smc_chk
#(
  parameter logic [7:0][4:0] P_SETTLE_EXP = `SMC_SETTLE_EXP
)
(
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [31:0]        i_paddr,
  input wire logic [31:0]        i_pwdata,
  input wire logic [3:0]         i_pstrb,
  input wire logic               i_halt_instr,
  input wire smc_pkg::smc_wake_t i_wake,
  input wire logic               i_osc_running,
  input wire smc_pkg::smc_clk_t  o_clk,
  input wire logic               o_standby,
  input wire logic               o_settling
);
  wire        wr   = i_psel && i_penable && i_pwrite && i_pstrb[0];
  wire        stop_request_bit  = wr && i_paddr == `SMC_ADDR_PSC && i_pwdata[1];
  wire        norm = o_clk.cpu_en;
  wire [2:0]  wk   = i_wake;
  logic [2:0] blk_r;
  logic [2:0] osc_settle_time_select_r;
  logic       sel_r;
  int         cnt_r;
  // register mirrors, so each rule is judged from the bus alone
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      blk_r <= 3'h0;
      osc_settle_time_select_r <= 3'h1;
      sel_r <= 1'b0;
      cnt_r <= 0;
    end
    else
    begin
      cnt_r <= o_settling ? cnt_r + int'(i_osc_running) : 0;
      if (wr && i_paddr == `SMC_ADDR_PSC && !i_pwdata[1])
        blk_r <= {i_pwdata[5], i_pwdata[7], i_pwdata[4]};
      if (wr && i_paddr == `SMC_ADDR_OSC_SETTLE_TIME_SELECT)
        osc_settle_time_select_r <= i_pwdata[2:0];
      if (wr && i_paddr == `SMC_ADDR_POWER_SAVE_MODE_REG)
        sel_r <= i_pwdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_stop; norm && stop_request_bit |=> o_standby && !o_clk.cpu_en && !o_clk.periph_en; endproperty
  property p_sel_stop; norm && stop_request_bit |=> o_clk.osc_en == !sel_r; endproperty
  property p_sel_none; norm && !stop_request_bit && !i_halt_instr |=> norm; endproperty
  property p_halt; norm && i_halt_instr && !stop_request_bit |=> o_clk.periph_en && !norm; endproperty
  property p_halt_osc; o_clk.periph_en |-> o_clk.osc_en; endproperty
  property p_halt_keep; !norm && o_clk.periph_en |=> o_clk.periph_en; endproperty
  property p_wake_blk; o_standby && (wk & ~blk_r) == 3'h0 |=> o_standby; endproperty
  property p_wake_go; o_standby && (wk & ~blk_r) != 3'h0 |=> !o_standby; endproperty
  // counts only edges with a running clock, so start-up lag never shortens the wait
  property p_settle; $fell(o_settling) |-> cnt_r == (1 << P_SETTLE_EXP[osc_settle_time_select_r]) + 1; endproperty
  a_stop: assert property (p_stop) else $error("stop entry");
  a_sel_stop: assert property (p_sel_stop) else $error("standby type");
  a_sel_none: assert property (p_sel_none) else $error("left normal");
  a_halt: assert property (p_halt) else $error("halt entry");
  a_halt_osc: assert property (p_halt_osc) else $error("osc off");
  a_halt_keep: assert property (p_halt_keep) else $error("periph lost");
  a_wake_blk: assert property (p_wake_blk) else $error("blocked wake");
  a_wake_go: assert property (p_wake_go) else $error("missed wake");
  a_settle: assert property (p_settle) else $error("settle len");
  c_stop: cover property (norm && stop_request_bit);
  c_blk: cover property (o_standby && wk != 3'h0 && (wk & ~blk_r) == 3'h0);
  c_settle: cover property ($fell(o_settling));
endmodule
bind smc_top smc_chk #(.P_SETTLE_EXP(P_SETTLE_EXP)) u_chk (.i_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .i_halt_instr, .i_wake,
  .i_osc_running, .o_clk, .o_standby, .o_settling);

// ==== verification/smc_tb_top.sv ====
`timescale 1ns/10ps
`include "smc_consts.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module smc_tb_top;
  localparam logic [7:0][4:0] EXP = {5'h07, 5'h06, 5'h05, 5'h05, 5'h04, 5'h04, 5'h03, 5'h02};
  logic               i_clk = 1'b0;
  logic               i_rst_n = 1'b0;
  logic               i_psel = 1'b0;
  logic               i_penable = 1'b0;
  logic               i_pwrite = 1'b0;
  logic [31:0]        i_paddr = '0;
  logic [31:0]        i_pwdata = '0;
  logic [3:0]         i_pstrb = 4'hf;
  logic               i_halt_instr = 1'b0;
  smc_pkg::smc_wake_t i_wake = '0;
  logic [2:0]         dly = 3'h0;
  logic               o_pready, o_pslverr, o_standby, o_settling, i_osc_running, e;
  logic [31:0]        o_prdata, q;
  smc_pkg::smc_clk_t  o_clk;
  integer             seed = 32'h0000_95eb;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  int                 n, len;
  always #25 i_clk = ~i_clk;
  smc_top #(.P_SETTLE_EXP(EXP)) dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .i_halt_instr,
    .i_wake, .i_osc_running, .o_clk, .o_standby, .o_settling);
  smc_osc_model u_osc (.i_clk, .i_rst_n, .i_osc_en(o_clk.osc_en), .i_delay(dly),
    .o_osc_running(i_osc_running));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h00_0000, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wait_norm(input int lim);
    n = 0;
    while (o_clk.cpu_en !== 1'b1 && n < lim)
    begin
      @(posedge i_clk);
      n++;
    end
  endtask
  function automatic logic [7:0] blk(input int i);
    return (i == 2) ? 8'h20 : (i == 1) ? 8'h80 : 8'h10;
  endfunction
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(2);
    `CHK(o_settling, 1'b1)
    i_rst_n <= 1'b1;
    wait_norm(200);
    apb(1'b0, `SMC_ADDR_OSC_SETTLE_TIME_SELECT, 8'h00);
    `CHK(q, 32'h0000_0001)
    apb(1'b0, `SMC_ADDR_POWER_SAVE_MODE_REG, 8'h00);
    `CHK(q, 32'h0000_0000)
    apb(1'b0, `SMC_ADDR_STAT + 32'h0000_0010, 8'h00);
    `CHK(e, 1'b1)
    for (int c = 0; c < 8; c++)
    begin
      len = $random(seed);
      apb(1'b1, `SMC_ADDR_POWER_SAVE_MODE_REG, len[7:0]);
      apb(1'b0, `SMC_ADDR_POWER_SAVE_MODE_REG, 8'h00);
      `CHK(q, 32'(len[0]))
      apb(1'b1, `SMC_ADDR_POWER_SAVE_MODE_REG, 8'h01);
      tick(2);
      `CHK(o_clk, 3'b111)
      apb(1'b1, `SMC_ADDR_OSC_SETTLE_TIME_SELECT, 8'(c));
      apb(1'b0, `SMC_ADDR_OSC_SETTLE_TIME_SELECT, 8'h00);
      `CHK(q, 32'(c))
      apb(1'b1, `SMC_ADDR_PSC, 8'h02);
      tick(1);
      `CHK(o_standby, 1'b1)
      `CHK(o_clk, 3'b000)
      dly <= 3'($random(seed));
      tick(1);
      i_wake <= 3'(1 << (c % 3));
      tick(1);
      i_wake <= 3'h0;
      wait_norm(400);
      len = 1 << EXP[c];
      `CHK(n >= len && n <= len + 12, 1'b1)
    end
    // each source in turn: a block set with the stop bit must not count
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `SMC_ADDR_POWER_SAVE_MODE_REG, 8'h00);
      apb(1'b1, `SMC_ADDR_PSC, blk(i) | 8'h02);
      tick(1);
      i_wake <= 3'(1 << i);
      tick(2);
      `CHK(o_standby, 1'b0)
      i_wake <= 3'h0;
      apb(1'b1, `SMC_ADDR_PSC, blk(i));
      apb(1'b1, `SMC_ADDR_PSC, 8'h02);
      tick(1);
      i_wake <= 3'(1 << i);
      tick(3);
      `CHK(o_standby, 1'b1)
      i_wake <= 3'(1 << ((i + 1) % 3));
      tick(2);
      `CHK(o_standby, 1'b0)
      i_wake <= 3'h0;
      apb(1'b1, `SMC_ADDR_PSC, 8'h00);
    end
    apb(1'b1, `SMC_ADDR_PSC, 8'hb0);
    i_halt_instr <= 1'b1;
    tick(1);
    i_halt_instr <= 1'b0;
    tick(1);
    `CHK(o_clk, 3'b101)
    tick(4);
    `CHK(o_clk, 3'b101)
    i_wake <= 3'h4;
    tick(2);
    `CHK(o_clk.cpu_en, 1'b1)
    i_wake <= 3'h0;
    i_rst_n <= 1'b0;
    tick(2);
    `CHK(o_clk, 3'b100)
    i_rst_n <= 1'b1;
    wait_norm(200);
    apb(1'b0, `SMC_ADDR_OSC_SETTLE_TIME_SELECT, 8'h00);
    `CHK(q, 32'h0000_0001)
    test_done;
  end
  initial
  begin
    tick(20000);
    num_errors++;
    test_done;
  end
endmodule
